// file: inc/icd_pkg.sv
// package: constants and types for the io cell pair with ddr capture
package icd_pkg;

    // ==========================================
    // register map (byte addresses)
    localparam logic [7:0] ICD_ADR_CTRL = 8'h00;
    localparam logic [7:0] ICD_ADR_STAT = 8'h04;
    localparam logic [7:0] ICD_ADR_DATA = 8'h08;

    // ==========================================
    // control field positions and reset value
    localparam int ICD_CTRL_WIDTH = 9;
    localparam int ICD_BIT_DDR = 0;
    localparam int ICD_BIT_DYN = 1;
    localparam int ICD_BIT_DIFF = 2;
    localparam int ICD_BIT_GEAR = 3;
    localparam int ICD_BIT_SRVAL = 4;
    localparam int ICD_FIX_LSB = 5;
    localparam logic [8:0] ICD_CTRL_RST = 9'h000;

    // ==========================================
    // status field positions
    localparam int ICD_STAT_POL = 0;
    localparam int ICD_STAT_LOCK = 1;
    localparam int ICD_STAT_ARMED = 2;
    localparam int ICD_STAT_CNT_LSB = 8;

    // ==========================================
    // input delay line
    localparam int ICD_DLY_DEPTH = 16;
    localparam logic [3:0] ICD_DLY_FIX_RST = 4'h0;

    typedef struct packed
    {
        logic [3:0] fixDly;
        logic srVal;
        logic gearbox;
        logic diffPair;
        logic dynDly;
        logic ddrMode;
    } icd_ctrl_s;

    typedef struct packed
    {
        logic fall;
        logic rise;
    } icd_pair_s;

    typedef enum logic [2:0]
    {
        ICD_POL_IDLE = 3'b001,
        ICD_POL_ARMED = 3'b010,
        ICD_POL_LOCKED = 3'b100
    } icd_pol_e;

endpackage

// file: tb/icd_ddr_mem.sv
// partner model: memory side of a ddr read burst
module icd_ddr_mem
(
    input wire logic go,
    input wire logic [7:0] data,
    output logic strobe,
    output logic dq,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;

    // strobe period 400 ns, data centred on each strobe edge
    initial
    begin
        strobe = 1'b1;
        dq = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge go);
            busy = 1'b1;
            #130 strobe = 1'b0;
            #300 dq = data[0];
            for (int i = 0; i < 4; i++)
            begin
                dq = data[2*i];
                #100 strobe = 1'b1;
                #100 dq = data[2*i+1];
                #100 strobe = 1'b0;
                #100;
            end
            // released: strobe pulled high, data line no longer valid
            strobe = 1'b1;
            dq = ~dq;
            busy = 1'b0;
        end
    end
endmodule

// file: tb/icd_io_cell_pair_chk.sv
// checker: port-level properties of the io cell pair
module icd_io_cell_pair_chk
    import icd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic padInT,
    input wire logic padOutT,
    input wire logic padOeT,
    input wire logic padOeC,
    input wire logic strobeIn,
    input wire logic coreClkEn,
    input wire logic localSetReset,
    input wire logic globalSetReset_n,
    input wire logic unregisteredIn,
    input wire logic clockNetTap,
    input wire logic registeredIn,
    input wire logic syncClockPolarity
);
    logic [3:0] sinceFall_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // =========================================
    // helpers
    // polarity may only move shortly after a strobe fall
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            sinceFall_ff <= 4'hF;
        else if ($fell(strobeIn))
            sinceFall_ff <= 4'h0;
        else if (sinceFall_ff != 4'hF)
            sinceFall_ff <= sinceFall_ff + 4'h1;
    end

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_padQuiet;
        $stable(padInT) [*5];
    endsequence
    // set/reset also reaches through the 2-stage sync, so look back 3
    sequence s_noSr;
        globalSetReset_n && $past(globalSetReset_n, 3) && !localSetReset
            && !$past(localSetReset);
    endsequence

    // =========================================
    // properties
    a_ack_after_req: assert property (s_req |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_bypass_follows: assert property (s_padQuiet ##0 s_noSr |-> unregisteredIn == padInT)
        else $error("bypass input off pad level");
    a_tap_follows: assert property (s_padQuiet ##0 s_noSr |-> clockNetTap == padInT)
        else $error("clock tap off pad level");
    a_hold_no_ce: assert property (s_noSr ##0 !$past(coreClkEn) |-> $stable(registeredIn) && $stable(padOutT))
        else $error("flop moved without clock enable");
    a_sr_local: assert property (localSetReset |=> !padOeT && !padOeC)
        else $error("local set/reset left driver on");
    a_gsr_oe_off: assert property (!globalSetReset_n [*3] |=> !padOeT)
        else $error("global set/reset left driver on");
    a_pol_needs_fall: assert property ($changed(syncClockPolarity) |-> sinceFall_ff <= 4'h8)
        else $error("polarity moved without preamble");
endmodule

bind icd_io_cell_pair icd_io_cell_pair_chk u_chk(.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .padInT(padInT), .padOutT(padOutT), .padOeT(padOeT), .padOeC(padOeC),
    .strobeIn(strobeIn), .coreClkEn(coreClkEn), .localSetReset(localSetReset),
    .globalSetReset_n(globalSetReset_n), .unregisteredIn(unregisteredIn),
    .clockNetTap(clockNetTap), .registeredIn(registeredIn),
    .syncClockPolarity(syncClockPolarity));

// file: tb/test_io_cell_ddr_capture.sv
// testbench: registers, sdr paths, set/reset and ddr reads of the io cell pair
module test_io_cell_ddr_capture
    import icd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [8:0] ctrl; logic [3:0] out; logic trist; logic pin;
        logic [3:0] exp;} icd_row_s;
    // exp = {padOutT, padOutC, padOeT, registeredIn}
    localparam icd_row_s ROWS [4] = '{'{9'h000, 4'h1, 1'b0, 1'b1, 4'hB},
        '{9'h000, 4'h4, 1'b1, 1'b0, 4'h4}, '{9'h004, 4'h5, 1'b0, 1'b1, 4'hB},
        '{9'h004, 4'h0, 1'b0, 1'b0, 4'h6}};
    localparam logic [7:0] BURST [2] = '{8'hB4, 8'h2D};
    // five extra cycles of input delay: run-time pick, then fixed field
    localparam logic [31:0] DLY_CTRL [2] = '{32'h0000_0002, 32'h0000_00A0};
    logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, coreOutData, dynDelaySel;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic padInT, padInC, padOutT, padOutC, padOeT, padOeC, strobeIn, coreClkEn;
    logic localSetReset, globalSetReset_n, readStart, writeTransferCtl, sdrTristate;
    logic [1:0] ddrTristatePair, gearboxRiseOut, gearboxFallOut;
    logic unregisteredIn, clockNetTap, registeredIn, syncClockPolarity, pol;
    icd_pair_s ddrInPair;
    logic sdrPin, ddrSel, memGo, memDq, memBusy;
    logic [7:0] memData;
    int failCount, compares, cycles;

    assign padInT = ddrSel ? memDq : sdrPin;
    assign padInC = ~padInT;

    icd_io_cell_pair u_dut(.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .padInT(padInT),
        .padInC(padInC), .padOutT(padOutT), .padOutC(padOutC), .padOeT(padOeT),
        .padOeC(padOeC), .strobeIn(strobeIn), .coreClkEn(coreClkEn),
        .localSetReset(localSetReset), .globalSetReset_n(globalSetReset_n),
        .readStart(readStart), .writeTransferCtl(writeTransferCtl),
        .dynDelaySel(dynDelaySel), .coreOutData(coreOutData), .sdrTristate(sdrTristate),
        .ddrTristatePair(ddrTristatePair), .unregisteredIn(unregisteredIn),
        .clockNetTap(clockNetTap), .registeredIn(registeredIn), .ddrInPair(ddrInPair),
        .gearboxRiseOut(gearboxRiseOut), .gearboxFallOut(gearboxFallOut),
        .syncClockPolarity(syncClockPolarity));
    icd_ddr_mem u_mem(.go(memGo), .data(memData), .strobe(strobeIn), .dq(memDq),
        .busy(memBusy));

    // =========================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failCount++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            failCount++;
            close_out();
        end
    end

    // =========================================
    // main sequence
    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {localSetReset, readStart, writeTransferCtl, sdrTristate, sdrPin, ddrSel} = '0;
        {dynDelaySel, coreOutData, ddrTristatePair, memGo, memData} = '0;
        {failCount, compares, cycles} = '0;
        sys_rst = 1'b1;
        globalSetReset_n = 1'b1;
        coreClkEn = 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        wb(0, ICD_ADR_CTRL, 4'hF, 0, rd);
        chk("ctrlReset", rd, {23'h0, ICD_CTRL_RST});
        wb(1, ICD_ADR_CTRL, 4'h1, 32'h1FF, rd);
        wb(0, ICD_ADR_CTRL, 4'hF, 0, rd);
        chk("ctrlLane0", rd, 32'hFF);
        wb(1, 8'h0C, 4'hF, 32'hFFFF, rd);
        wb(0, 8'h0C, 4'hF, 0, rd);
        chk("unmapped", rd, 32'h0);
        $display("register test done");
        foreach (ROWS[i])
        begin
            wb(1, ICD_ADR_CTRL, 4'h3, {23'h0, ROWS[i].ctrl}, rd);
            coreOutData <= ROWS[i].out;
            sdrTristate <= ROWS[i].trist;
            sdrPin <= ROWS[i].pin;
            repeat (6) @(posedge clk);
            chk("outs", {padOutT, padOutC, padOeT, registeredIn}, ROWS[i].exp);
            chk("oeC", padOeC, ROWS[i].exp[1]);
            chk("bypass", {clockNetTap, unregisteredIn}, {2{ROWS[i].pin}});
            wb(0, ICD_ADR_DATA, 4'hF, 0, rd);
            chk("padSync", rd[1:0], {~ROWS[i].pin, ROWS[i].pin});
            $display("row %0d done", i);
        end
        // clock enable low: registers hold while bypass follows the pad
        coreClkEn <= 1'b0;
        coreOutData <= 4'hF;
        sdrPin <= 1'b1;
        repeat (6) @(posedge clk);
        chk("ceHold", {padOutT, registeredIn, unregisteredIn}, 3'b001);
        coreClkEn <= 1'b1;
        $display("clock enable test done");
        wb(1, ICD_ADR_CTRL, 4'h3, 32'h10, rd);
        localSetReset <= 1'b1;
        repeat (3) @(posedge clk);
        chk("localSr", {padOutT, padOutC, padOeT, registeredIn}, 4'h9);
        localSetReset <= 1'b0;
        globalSetReset_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk("globalSr", {padOutT, padOutC, padOeT, registeredIn}, 4'h9);
        globalSetReset_n <= 1'b1;
        repeat (4) @(posedge clk);
        $display("set/reset test done");
        dynDelaySel <= 4'h5;
        foreach (DLY_CTRL[j])
        begin
            wb(1, ICD_ADR_CTRL, 4'h3, DLY_CTRL[j], rd);
            sdrPin <= j[0];
            repeat (5) @(posedge clk);
            chk("dlyEarly", registeredIn, j == 0);
            repeat (5) @(posedge clk);
            chk("dlyLate", registeredIn, j != 0);
        end
        $display("input delay test done");
        wb(1, ICD_ADR_CTRL, 4'h3, 32'h9, rd);
        ddrSel <= 1'b1;
        foreach (BURST[k])
        begin
            readStart <= 1'b1;
            @(posedge clk);
            readStart <= 1'b0;
            memData <= BURST[k];
            memGo <= 1'b1;
            @(posedge clk);
            memGo <= 1'b0;
            do @(posedge clk); while (memBusy === 1'b1);
            repeat (10) @(posedge clk);
            chk("pair", ddrInPair, BURST[k][7:6]);
            chk("gearRise", gearboxRiseOut, {BURST[k][6], BURST[k][4]});
            chk("gearFall", gearboxFallOut, {BURST[k][7], BURST[k][5]});
            wb(0, ICD_ADR_STAT, 4'hF, 0, rd);
            chk("locked", rd[ICD_STAT_LOCK], 1'b1);
            $display("burst %0d done", k);
        end
        // ddr output: rise and fall data alternate, transfer control freezes
        coreOutData <= 4'hA;
        ddrTristatePair <= 2'h0;
        repeat (4) @(posedge clk);
        pol = padOutT;
        @(posedge clk);
        chk("ddrOut", {padOutT, padOutC, padOeT}, {!pol, !pol, 1'b1});
        writeTransferCtl <= 1'b1;
        repeat (2) @(posedge clk);
        pol = padOutT;
        @(posedge clk);
        chk("xferFreeze", padOutT, pol);
        writeTransferCtl <= 1'b0;
        ddrTristatePair <= 2'h1;
        repeat (4) @(posedge clk);
        pol = padOeT;
        @(posedge clk);
        chk("ddrOe", padOeT, !pol);
        $display("ddr output test done");
        // read armed but no preamble: polarity must stay put
        pol = syncClockPolarity;
        readStart <= 1'b1;
        @(posedge clk);
        readStart <= 1'b0;
        repeat (40) @(posedge clk);
        chk("polKept", syncClockPolarity, pol);
        $display("no preamble test done");
        close_out();
    end
endmodule

// file: verilog/icd_io_cell_pair.sv
// module: one io cell pair (true and complement slices) with sdr/ddr capture
module icd_io_cell_pair
    import icd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pads
    input wire logic padInT,
    input wire logic padInC,
    output logic padOutT,
    output logic padOutC,
    output logic padOeT,
    output logic padOeC,
    input wire logic strobeIn,
    // core side
    input wire logic coreClkEn,
    input wire logic localSetReset,
    input wire logic globalSetReset_n,
    input wire logic readStart,
    input wire logic writeTransferCtl,
    input wire logic [3:0] dynDelaySel,
    input wire logic [3:0] coreOutData,
    input wire logic sdrTristate,
    input wire logic [1:0] ddrTristatePair,
    output logic unregisteredIn,
    output logic clockNetTap,
    output logic registeredIn,
    output icd_pair_s ddrInPair,
    output logic [1:0] gearboxRiseOut,
    output logic [1:0] gearboxFallOut,
    output logic syncClockPolarity
);

    // ==========================================
    // helpers
    function automatic logic slotNext(input logic cur, input logic nxt, input logic load,
                                      input logic sr, input logic srVal);
        logic res;
        res = cur;
        if (sr)
            res = srVal;
        else if (load)
            res = nxt;
        return res;
    endfunction

    // ==========================================
    // pin synchronisers
    logic [1:0] inTSync_ff;
    logic [1:0] inCSync_ff;
    logic [1:0] strbSync_ff;
    logic [1:0] gsrnSync_ff;
    logic strbLast_ff;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            inTSync_ff <= 2'h0;
            inCSync_ff <= 2'h0;
            strbSync_ff <= 2'h3;
            gsrnSync_ff <= 2'h0;
            strbLast_ff <= 1'b1;
        end
        else
        begin
            inTSync_ff <= {inTSync_ff[0], padInT};
            inCSync_ff <= {inCSync_ff[0], padInC};
            strbSync_ff <= {strbSync_ff[0], strobeIn};
            gsrnSync_ff <= {gsrnSync_ff[0], globalSetReset_n};
            strbLast_ff <= strbSync_ff[1];
        end
    end

    logic padT;
    logic padC;
    logic strbRise;
    logic strbFall;
    logic srActive;
    assign padT = inTSync_ff[1];
    assign padC = inCSync_ff[1];
    assign strbRise = strbSync_ff[1] & ~strbLast_ff;
    assign strbFall = ~strbSync_ff[1] & strbLast_ff;
    // global and local set/reset share one request
    assign srActive = ~gsrnSync_ff[1] | localSetReset;

    // ==========================================
    // control register over wishbone
    icd_ctrl_s ctrl_ff;
    logic wbReq;
    logic wbHit;
    assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl_ff <= icd_ctrl_s'(ICD_CTRL_RST);
        else if (wbReq && wb_we_i && wb_adr_i == ICD_ADR_CTRL)
        begin
            if (wb_sel_i[0])
                ctrl_ff[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                ctrl_ff[8] <= wb_dat_i[8];
        end
    end

    // ==========================================
    // input delay line, fixed or dynamic tap
    logic [ICD_DLY_DEPTH-1:0] dlyLine_ff;
    logic [3:0] dlyTap;
    logic padDly;
    assign dlyTap = ctrl_ff.dynDly ? dynDelaySel : ctrl_ff.fixDly;
    // tap 0 means no added delay
    assign padDly = (dlyTap == 4'h0) ? padT : dlyLine_ff[dlyTap - 4'h1];

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            dlyLine_ff <= '0;
        else
            dlyLine_ff <= {dlyLine_ff[ICD_DLY_DEPTH-2:0], padT};
    end

    // ==========================================
    // bypass paths
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            unregisteredIn <= 1'b0;
            clockNetTap <= 1'b0;
        end
        else
        begin
            // raw pad level, no delay and no enable
            unregisteredIn <= padT;
            clockNetTap <= padT;
        end
    end

    // ==========================================
    // sdr input register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            registeredIn <= 1'b0;
        else
            registeredIn <= slotNext(registeredIn, padDly, coreClkEn, srActive,
                                     ctrl_ff.srVal);
    end

    // ==========================================
    // read-cycle polarity selection
    icd_pol_e polState_ff;
    logic phase_ff;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            phase_ff <= 1'b0;
        else
            phase_ff <= ~phase_ff;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            polState_ff <= ICD_POL_IDLE;
        else
        begin
            case (polState_ff)
                ICD_POL_IDLE:
                    if (readStart)
                        polState_ff <= ICD_POL_ARMED;
                ICD_POL_ARMED:
                    // strobe leaves its parked high at preamble
                    if (strbFall)
                        polState_ff <= ICD_POL_LOCKED;
                ICD_POL_LOCKED:
                    if (readStart)
                        polState_ff <= ICD_POL_ARMED;
                default:
                    polState_ff <= ICD_POL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            syncClockPolarity <= 1'b0;
        else if (polState_ff == ICD_POL_ARMED && strbFall)
            syncClockPolarity <= phase_ff;
        // otherwise hold: a read with no preamble keeps the old choice
        else
            syncClockPolarity <= syncClockPolarity;
    end

    // ==========================================
    // ddr capture on strobe edges
    logic riseStream_ff;
    logic fallStream_ff;
    logic pairPend_ff;
    logic ddrCap;
    logic handOff;
    assign ddrCap = ctrl_ff.ddrMode && polState_ff == ICD_POL_LOCKED && coreClkEn;
    // hand-off waits for the chosen phase, at most one extra cycle
    assign handOff = pairPend_ff && (phase_ff == syncClockPolarity);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            riseStream_ff <= 1'b0;
            fallStream_ff <= 1'b0;
        end
        else
        begin
            riseStream_ff <= slotNext(riseStream_ff, padDly, ddrCap && strbRise, srActive,
                                      ctrl_ff.srVal);
            fallStream_ff <= slotNext(fallStream_ff, padDly, ddrCap && strbFall, srActive,
                                      ctrl_ff.srVal);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pairPend_ff <= 1'b0;
        else if (srActive)
            pairPend_ff <= 1'b0;
        else if (ddrCap && strbFall)
            pairPend_ff <= 1'b1;
        else if (handOff)
            pairPend_ff <= 1'b0;
    end

    // ==========================================
    // system clock hand-off and gearbox
    logic gearSlot_ff;
    logic [1:0] pairCnt_ff;
    icd_pair_s gearLow_ff;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ddrInPair <= '0;
        else if (srActive)
            ddrInPair <= {ctrl_ff.srVal, ctrl_ff.srVal};
        else if (handOff)
            ddrInPair <= {fallStream_ff, riseStream_ff};
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gearSlot_ff <= 1'b0;
            gearLow_ff <= '0;
            gearboxRiseOut <= 2'h0;
            gearboxFallOut <= 2'h0;
        end
        else if (srActive)
        begin
            gearSlot_ff <= 1'b0;
            gearLow_ff <= {ctrl_ff.srVal, ctrl_ff.srVal};
            gearboxRiseOut <= {2{ctrl_ff.srVal}};
            gearboxFallOut <= {2{ctrl_ff.srVal}};
        end
        else if (handOff && ctrl_ff.gearbox)
        begin
            gearSlot_ff <= ~gearSlot_ff;
            // first pair parks in the gearLow_ff register until the second pair arrives
            if (!gearSlot_ff)
                gearLow_ff <= {fallStream_ff, riseStream_ff};
            else
            begin
                gearboxRiseOut <= {riseStream_ff, gearLow_ff.rise};
                gearboxFallOut <= {fallStream_ff, gearLow_ff.fall};
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pairCnt_ff <= 2'h0;
        else if (handOff)
            pairCnt_ff <= pairCnt_ff + 2'h1;
    end

    // ==========================================
    // output and tristate register blocks
    logic outLoad;
    logic nxtOutT;
    logic nxtOutC;
    logic nxtOe;
    // transfer control lets the core freeze the output block
    assign outLoad = coreClkEn & ~writeTransferCtl;

    always_comb
    begin
        if (ctrl_ff.ddrMode)
        begin
            nxtOutT = phase_ff ? coreOutData[1] : coreOutData[0];
            nxtOutC = phase_ff ? coreOutData[3] : coreOutData[2];
            nxtOe = ~(phase_ff ? ddrTristatePair[1] : ddrTristatePair[0]);
        end
        else
        begin
            nxtOutT = coreOutData[0];
            nxtOutC = coreOutData[2];
            nxtOe = ~sdrTristate;
        end
        // complement slice mirrors the true slice in a differential pair
        if (ctrl_ff.diffPair)
            nxtOutC = ~nxtOutT;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            padOutT <= 1'b0;
            padOutC <= 1'b0;
            padOeT <= 1'b0;
            padOeC <= 1'b0;
        end
        else
        begin
            padOutT <= slotNext(padOutT, nxtOutT, outLoad, srActive, ctrl_ff.srVal);
            padOutC <= slotNext(padOutC, nxtOutC, outLoad, srActive, ~ctrl_ff.srVal);
            padOeT <= slotNext(padOeT, nxtOe, outLoad, srActive, 1'b0);
            padOeC <= slotNext(padOeC, nxtOe, outLoad, srActive, 1'b0);
        end
    end

    // ==========================================
    // wishbone read side
    logic [31:0] rdData;
    assign wbHit = wb_adr_i == ICD_ADR_CTRL || wb_adr_i == ICD_ADR_STAT ||
                   wb_adr_i == ICD_ADR_DATA;

    always_comb
    begin
        rdData = 32'h0000_0000;
        case (wb_adr_i)
            ICD_ADR_CTRL:
                rdData[ICD_CTRL_WIDTH-1:0] = ctrl_ff;
            ICD_ADR_STAT:
            begin
                rdData[ICD_STAT_POL] = syncClockPolarity;
                rdData[ICD_STAT_LOCK] = polState_ff == ICD_POL_LOCKED;
                rdData[ICD_STAT_ARMED] = polState_ff == ICD_POL_ARMED;
                rdData[ICD_STAT_CNT_LSB+:2] = pairCnt_ff;
            end
            ICD_ADR_DATA:
                rdData[7:0] = {gearboxFallOut, gearboxRiseOut, ddrInPair, padC, padT};
            default:
                rdData = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            // unmapped addresses still ack, reading zero
            wb_ack_o <= wbReq;
            wb_dat_o <= (wbReq && !wb_we_i && wbHit) ? rdData : 32'h0000_0000;
        end
    end

endmodule
